// >>> port_cde_io.v
// Three-port I/O block with parallel slave port control
// What this block does
// - Select picks port latch or peripheral output per multifunction pin.
// - Peripheral output enable acts only while its select is active.
// - Multifunction bits 0-2 carry timer oscillator and compare units.
// - Bit 3 is serial clock, bit 4 serial data in.
// - Bit 5 can carry serial data output.
// - Bits 6 and 7 serve the USART transmit/clock and receive/data.
// - Each slave bus port pin has its own direction bit.
// - Mode select turns the data port into a parallel slave port.
// - In slave mode pin n carries slave bus bit n.
// - Each of three control pins has its own direction bit.
// - In slave mode control pins become read, write, chip select.
// - Control pins set analog read as zero.
// - Direction bits still drive outputs while pins are analog.
// - After reset the control pins are analog inputs.
// - Direction one means input, zero means output.
// - Bit 3 of control direction register reads zero.
// - Write latches bus data on first chip select and write low.
// - Read drives latch onto bus on first chip select and read low.
// - Chip select is active low; strobes ignored when high.
`include "port_cde_defs.vh"
`default_nettype none

module port_cde_io
(
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Multifunction port pins
  input wire [7:0] multifunction_port_in,
  output wire [7:0] multifunction_port_out,
  output wire [7:0] multifunction_port_oe,
  // Peripheral hookups, one bit per multifunction pin
  input wire [7:0] periph_sel,
  input wire [7:0] periph_out,
  input wire [7:0] periph_oe,
  output wire [7:0] periph_in,
  // Slave bus port pins
  input wire [7:0] slave_bus_port_in,
  output reg [7:0] slave_bus_port_out,
  output wire [7:0] slave_bus_port_oe,
  // Control port pins
  input wire [2:0] control_port_in,
  output reg [2:0] control_port_out,
  output wire [2:0] control_port_oe,
  // Named peripheral views of the multifunction pins
  output wire secondary_timer_osc_out_in,
  output wire secondary_timer_osc_in_in,
  output wire capture_compare_pwm_unit1_in,
  output wire sync_serial_clock_in,
  output wire sync_serial_data_in,
  output wire usart_sync_data_in,
  output wire slave_port_mode_select
);

  // ============================================================
  // Registers
  reg [7:0] mfp_latch_reg;
  reg [7:0] mfp_dir_reg;
  reg [7:0] sbp_latch_reg;
  reg [7:0] sbp_dir_reg;
  reg [2:0] ctl_dir_reg;
  reg mode_reg;
  reg in_full_reg;
  reg out_full_reg;
  reg overflow_reg;
  reg [2:0] ctl_latch_reg;
  reg [3:0] analog_cfg_reg;
  reg [7:0] rdata_next;
  reg [7:0] sbp_in_reg;
  reg drive_bus_reg;
  wire rd_start;
  wire wr_start;
  wire [2:0] ctl_analog;
  wire cpu_reads_sbp;
  wire cpu_writes_sbp;
  wire cpu_writes_ctl_dir;
  wire sel_mfp_data;
  wire sel_sbp_data;
  wire sel_ctl_data;
  wire sel_mfp_dir;
  wire sel_sbp_dir;
  wire sel_ctl_dir;
  wire sel_analog;

  assign slave_port_mode_select = mode_reg;

  // ============================================================
  // Multifunction pins
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_mfp
      pin_mux_bit u_bit
      (
        .port_latch(mfp_latch_reg[i]),
        .port_dir_in(mfp_dir_reg[i]),
        .periph_sel(periph_sel[i]),
        .periph_out(periph_out[i]),
        .periph_oe(periph_oe[i]),
        .pin_out(multifunction_port_out[i]),
        .pin_oe(multifunction_port_oe[i])
      );
    end
  endgenerate

  // Pins fan out to their peripherals; output side comes through periph_out
  assign periph_in = multifunction_port_in;
  assign secondary_timer_osc_out_in = multifunction_port_in[0];
  assign secondary_timer_osc_in_in = multifunction_port_in[1];
  assign capture_compare_pwm_unit1_in = multifunction_port_in[2];
  assign sync_serial_clock_in = multifunction_port_in[3];
  assign sync_serial_data_in = multifunction_port_in[4];
  assign usart_sync_data_in = multifunction_port_in[7];
  // serial data out arrives on periph_out[5] under periph_sel[5]

  // ============================================================
  // Analog selection of the control pins
  // Simplified map: codes below 4'h6 keep all three pins analog
  // Codes 4'h6 and up make them digital, as slave mode needs
  // analog after reset
  assign ctl_analog = (analog_cfg_reg < 4'h6) ? 3'h7 : 3'h0;

  // ============================================================
  // Slave strobe detection
  // Select on bit 2, write on bit 1, read on bit 0, all active low
  // control pins become strobes
  slave_strobe_sync u_strobe
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(mode_reg),
    .cs_n(control_port_in[2]),
    .rd_n(control_port_in[0]),
    .wr_n(control_port_in[1]),
    .rd_start(rd_start),
    .wr_start(wr_start)
  );

  // ============================================================
  // Pin drivers
  // Direction bits keep control of the strobe pins in slave mode too
  // per-pin control direction
  assign control_port_oe = ~ctl_dir_reg;

  // pin n carries bus bit n
  // drive bus while read is held
  assign slave_bus_port_oe = mode_reg ? {8{drive_bus_reg}} : ~sbp_dir_reg;

  // Registered data outputs
  // Registered so a register write never glitches a pin
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      slave_bus_port_out <= 8'h00;
      control_port_out <= 3'h0;
    end
    else
    begin
      slave_bus_port_out <= sbp_latch_reg;
      control_port_out <= ctl_latch_reg;
    end
  end

  // Bus driven from the read start until the strobe or select lifts
  // Dropped on the first clock edge after either line lifts, so the master is never fought
  always @(posedge ref_clk)
  begin
    if (rst)
      drive_bus_reg <= 1'b0;
    else if (rd_start)
      drive_bus_reg <= 1'b1;
    else if (!mode_reg || control_port_in[0] || control_port_in[2])
      drive_bus_reg <= 1'b0;
  end

  // ============================================================
  // Address decode, one select per register
  assign sel_mfp_data = (reg_addr == `MFP_DATA_ADDR);
  assign sel_sbp_data = (reg_addr == `SBP_DATA_ADDR);
  assign sel_ctl_data = (reg_addr == `CTL_DATA_ADDR);
  assign sel_mfp_dir = (reg_addr == `MFP_DIR_ADDR);
  assign sel_sbp_dir = (reg_addr == `SBP_DIR_ADDR);
  assign sel_ctl_dir = (reg_addr == `CTL_DIR_ADDR);
  assign sel_analog = (reg_addr == `ANALOG_CFG_ADDR);

  // Strobed accesses that move a flag
  assign cpu_reads_sbp = reg_rd && sel_sbp_data;
  assign cpu_writes_sbp = reg_wr && sel_sbp_data;
  assign cpu_writes_ctl_dir = reg_wr && sel_ctl_dir;

  // ============================================================
  // Port data latches
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mfp_latch_reg <= 8'h00;
      sbp_latch_reg <= 8'h00;
      ctl_latch_reg <= 3'h0;
    end
    else if (reg_wr)
    begin
      if (sel_mfp_data)
        mfp_latch_reg <= reg_wdata;
      if (sel_sbp_data)
        sbp_latch_reg <= reg_wdata;
      if (sel_ctl_data)
        ctl_latch_reg <= reg_wdata[2:0];
    end
  end

  // ============================================================
  // Direction, mode and analog configuration
  // Directions reset to inputs so no pin drives before software asks
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mfp_dir_reg <= `MFP_DIR_RESET;
      sbp_dir_reg <= `SBP_DIR_RESET;
      ctl_dir_reg <= `CTL_DIR_RESET;
      mode_reg <= 1'b0;
      analog_cfg_reg <= `ANALOG_CFG_RESET;
    end
    else if (reg_wr)
    begin
      if (sel_mfp_dir)
        mfp_dir_reg <= reg_wdata;
      if (sel_sbp_dir)
        sbp_dir_reg <= reg_wdata;
      if (sel_analog)
        analog_cfg_reg <= reg_wdata[3:0];
      if (sel_ctl_dir)
      begin
        // one direction bit per control pin
        ctl_dir_reg <= reg_wdata[2:0];
        mode_reg <= reg_wdata[`MODE_SEL_POS];
      end
    end
  end

  // ============================================================
  // Slave-port input byte and status flags
  // latch external data
  always @(posedge ref_clk)
  begin
    if (rst)
      sbp_in_reg <= 8'h00;
    else if (wr_start)
      sbp_in_reg <= slave_bus_port_in;
  end

  // input full flag, set beats clear
  always @(posedge ref_clk)
  begin
    if (rst)
      in_full_reg <= 1'b0;
    else if (wr_start)
      in_full_reg <= 1'b1;
    else if (cpu_reads_sbp)
      in_full_reg <= 1'b0;
  end

  // output full flag, CPU write wins
  always @(posedge ref_clk)
  begin
    if (rst)
      out_full_reg <= 1'b0;
    else if (cpu_writes_sbp)
      out_full_reg <= 1'b1;
    else if (rd_start)
      out_full_reg <= 1'b0;
  end

  // overflow on write while full
  // Software can only clear it; a new overflow in the same cycle wins
  always @(posedge ref_clk)
  begin
    if (rst)
      overflow_reg <= 1'b0;
    else if (wr_start && in_full_reg)
      overflow_reg <= 1'b1;
    else if (cpu_writes_ctl_dir && !reg_wdata[`OVERFLOW_POS])
      overflow_reg <= 1'b0;
  end

  // ============================================================
  // Read mux
  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `MFP_DATA_ADDR: rdata_next = multifunction_port_in;
      // Slave mode returns the byte the external master wrote
      `SBP_DATA_ADDR: rdata_next = mode_reg ? sbp_in_reg : slave_bus_port_in;
      `CTL_DATA_ADDR: rdata_next = {5'h00, control_port_in & ~ctl_analog};
      `MFP_DIR_ADDR: rdata_next = mfp_dir_reg;
      `SBP_DIR_ADDR: rdata_next = sbp_dir_reg;
      `CTL_DIR_ADDR: rdata_next = {in_full_reg, out_full_reg, overflow_reg, mode_reg, 1'b0, ctl_dir_reg};
      // Unmapped addresses fall through to zero
      `ANALOG_CFG_ADDR: rdata_next = {4'h0, analog_cfg_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 8'h00;
  end

endmodule // port_cde_io

`default_nettype wire

// >>> port_cde_defs.vh
// Constants for the three-port general purpose I/O block
`ifndef PORT_CDE_DEFS_VH
`define PORT_CDE_DEFS_VH

// ============================================================
// Register offsets
`define MFP_DATA_ADDR 8'h07
`define SBP_DATA_ADDR 8'h08
`define CTL_DATA_ADDR 8'h09
`define MFP_DIR_ADDR 8'h87
`define SBP_DIR_ADDR 8'h88
`define CTL_DIR_ADDR 8'h89
`define ANALOG_CFG_ADDR 8'h9F

// ============================================================
// Reset values
`define MFP_DIR_RESET 8'hFF
`define SBP_DIR_RESET 8'hFF
`define CTL_DIR_RESET 3'h7
`define ANALOG_CFG_RESET 4'h0

// ============================================================
// Control and status field positions
`define IN_FULL_POS 7
`define OUT_FULL_POS 6
`define OVERFLOW_POS 5
`define MODE_SEL_POS 4

`endif

// >>> pin_mux_bit.v
// One pin of the multifunction port with peripheral override
`default_nettype none

module pin_mux_bit
(
  input wire port_latch,
  input wire port_dir_in,
  input wire periph_sel,
  input wire periph_out,
  input wire periph_oe,
  output wire pin_out,
  output wire pin_oe
);

  // ============================================================
  // Output mux
  // data source select
  assign pin_out = periph_sel ? periph_out : port_latch;
  assign pin_oe = periph_sel ? periph_oe : ~port_dir_in;

endmodule // pin_mux_bit

`default_nettype wire

// >>> slave_strobe_sync.v
// Detects first-low of chip select with a read or write strobe
`default_nettype none

module slave_strobe_sync
(
  input wire ref_clk,
  input wire rst,
  input wire enable,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  output wire rd_start,
  output wire wr_start
);

  reg rd_act_reg;
  reg wr_act_reg;
  wire rd_act;
  wire wr_act;

  // ============================================================
  // Active levels, chip select gates both strobes
  // deselect ignores strobes
  assign rd_act = enable & ~cs_n & ~rd_n;
  assign wr_act = enable & ~cs_n & ~wr_n;

  // Remember previous level so an access fires once only
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
    end
    else
    begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
    end
  end

  assign wr_start = wr_act & ~wr_act_reg;
  assign rd_start = rd_act & ~rd_act_reg;

endmodule // slave_strobe_sync

`default_nettype wire

// >>> port_cde_io_properties.sv
// Checker for the three-port I/O block
`default_nettype none
module port_cde_io_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] multifunction_port_out,
  input wire logic [7:0] multifunction_port_oe,
  input wire logic [7:0] periph_sel,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] slave_bus_port_in,
  input wire logic [7:0] slave_bus_port_out,
  input wire logic [7:0] slave_bus_port_oe,
  input wire logic [2:0] control_port_in,
  input wire logic [2:0] control_port_oe,
  input wire logic slave_port_mode_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Byte the external master last wrote, kept for the read-back check
  wire wr_low = slave_port_mode_select && control_port_in[2:1] == 2'h0;
  logic wr_low_reg;
  logic [7:0] ext_byte_reg;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_low_reg <= 1'b0;
      ext_byte_reg <= 8'h00;
    end
    else
    begin
      wr_low_reg <= wr_low;
      if (wr_low && !wr_low_reg)
        ext_byte_reg <= slave_bus_port_in;
    end
  end
  // ============================================================
  // Pin multiplexing and reset state
  chk_mux_value: assert property (
    (multifunction_port_out & periph_sel) == (periph_out & periph_sel)) else $error("mux value");
  chk_oe_gate: assert property (
    (multifunction_port_oe & periph_sel) == (periph_oe & periph_sel)) else $error("oe gate");
  chk_reset_inputs: assert property (
    $fell(rst) |-> control_port_oe == 3'h0 && slave_bus_port_oe == 8'h00) else $error("reset dirs");
  chk_unused_bit: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h89 |-> !reg_rdata[3]) else $error("bit3 set");
  // ============================================================
  // Slave bus strobes, active low: bit2 select, bit1 write, bit0 read
  chk_write_latch: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h08 && $past(slave_port_mode_select)
    |-> reg_rdata == $past(ext_byte_reg)) else $error("write latch");
  chk_read_drive: assert property (
    slave_port_mode_select && {control_port_in[2], control_port_in[0]} == 2'h0
    && $past({control_port_in[2], control_port_in[0]}) != 2'h0 |=> slave_bus_port_oe == 8'hFF)
    else $error("read drive");
  chk_read_release: assert property (
    slave_port_mode_select && $rose(control_port_in[0]) |-> ##[1:2] slave_bus_port_oe == 8'h00)
    else $error("read release");
  chk_select_idle: assert property (
    slave_port_mode_select && $past(slave_port_mode_select) && control_port_in[2] && $past(control_port_in[2])
    |-> slave_bus_port_oe == 8'h00) else $error("bus driven unselected");
endmodule // port_cde_io_chk

bind port_cde_io port_cde_io_chk i_port_cde_io_chk (.ref_clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
  .multifunction_port_out, .multifunction_port_oe, .periph_sel, .periph_out, .periph_oe, .slave_bus_port_in,
  .slave_bus_port_out, .slave_bus_port_oe, .control_port_in, .control_port_oe, .slave_port_mode_select);
`default_nettype wire

// >>> ext_bus_model.sv
// Model of the external microprocessor on the slave bus
`default_nettype none
module ext_bus_model
(
  input wire logic clk,
  input wire logic [7:0] bus,
  output var logic [2:0] ctl_n,
  output var logic [7:0] drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: strobes high, bus value arbitrary
  initial
  begin
    ctl_n = 3'h7;
    drive = 8'h00;
  end
  // ============================================================
  // One access; strobes are select, write, read, all active low
  // whole byte, strobes held then all released
  task automatic access(input logic [2:0] strobes, input logic [7:0] wdata, input int hold,
    output logic [7:0] rdata);
    @(posedge clk);
    ctl_n <= strobes;
    drive <= wdata;
    repeat (hold) @(posedge clk);
    rdata = bus;
    ctl_n <= 3'h7;
    // Released bus must not keep showing the old byte
    drive <= ~wdata;
  endtask
endmodule // ext_bus_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the three-port I/O block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, mf_in = 0, p_sel = 0, p_out = 0, p_oe = 0, got;
  wire [7:0] reg_rdata, mf_out, mf_oe, mf_pin, p_in, sbp_out, sbp_oe, sbp_pin, ext_drive;
  wire [2:0] ctl_n, ctl_out, ctl_oe, ctl_pin;
  wire [5:0] views;
  wire mode_sel;
  int n_errors = 0, n_tests = 0;
  // Pin levels: whoever enables its driver wins the bit
  assign mf_pin = (mf_oe & mf_out) | (~mf_oe & mf_in);
  assign sbp_pin = (sbp_oe & sbp_out) | (~sbp_oe & ext_drive);
  assign ctl_pin = (ctl_oe & ctl_out) | (~ctl_oe & ctl_n);
  port_cde_io i_port_cde_io (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .multifunction_port_in(mf_pin),
    .multifunction_port_out(mf_out), .multifunction_port_oe(mf_oe), .periph_sel(p_sel), .periph_out(p_out),
    .periph_oe(p_oe), .periph_in(p_in), .slave_bus_port_in(sbp_pin), .slave_bus_port_out(sbp_out),
    .slave_bus_port_oe(sbp_oe), .control_port_in(ctl_pin), .control_port_out(ctl_out),
    .control_port_oe(ctl_oe), .secondary_timer_osc_out_in(views[0]), .secondary_timer_osc_in_in(views[1]),
    .capture_compare_pwm_unit1_in(views[2]), .sync_serial_clock_in(views[3]), .sync_serial_data_in(views[4]),
    .usart_sync_data_in(views[5]), .slave_port_mode_select(mode_sel));
  ext_bus_model i_ext_bus_model (.clk(ref_clk), .bus(sbp_pin), .ctl_n(ctl_n), .drive(ext_drive));
  // ============================================================
  // Clock, verdict and shared tasks
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      n_errors++;
    end
  endtask
  // One-cycle strobes; a gap cycle keeps each strobe assigned once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
    @(posedge ref_clk);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd(8'h87, 8'hFF);
    rd(8'h88, 8'hFF);
    rd(8'h89, 8'h07);
    rd(8'h09, 8'h00);
    wr(8'h89, 8'h02);
    check({5'h0, ctl_oe}, 8'h05);
    wr(8'h9F, 8'h06);
    wr(8'h09, 8'h04);
    rd(8'h09, 8'h06);
    wr(8'h89, 8'h07);
  endtask
  task automatic t_mux;
    p_sel <= 8'h69;
    p_out <= 8'h0F;
    p_oe <= 8'h21;
    mf_in <= 8'hC3;
    wr(8'h07, 8'hA5);
    wr(8'h87, 8'h00);
    check(mf_out, 8'h8D);
    check(mf_oe, 8'hB7);
    check(p_in, 8'hC5);
    check({2'h0, views}, 8'h25);
    rd(8'h07, 8'hC5);
    wr(8'h87, 8'hFF);
    wr(8'h88, 8'h5A);
    check(sbp_oe, 8'hA5);
    wr(8'h88, 8'hFF);
  endtask
  task automatic t_slave;
    wr(8'h89, 8'h1F);
    rd(8'h89, 8'h17);
    check({7'h0, mode_sel}, 8'h01);
    i_ext_bus_model.access(3'h1, 8'h3C, 2, got);
    rd(8'h89, 8'h97);
    rd(8'h08, 8'h3C);
    rd(8'h89, 8'h17);
    i_ext_bus_model.access(3'h5, 8'hEE, 2, got);
    rd(8'h89, 8'h17);
    i_ext_bus_model.access(3'h1, 8'h11, 2, got);
    i_ext_bus_model.access(3'h1, 8'h22, 5, got);
    rd(8'h89, 8'hB7);
    rd(8'h08, 8'h22);
    wr(8'h89, 8'h17);
    rd(8'h89, 8'h17);
    wr(8'h08, 8'h69);
    rd(8'h89, 8'h57);
    i_ext_bus_model.access(3'h2, 8'h00, 3, got);
    check(got, 8'h69);
    rd(8'h89, 8'h17);
    wr(8'h89, 8'h07);
  endtask
  // Main sequence and hang guard
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_mux();
    t_slave();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
